// ==== verilog/pulse_chain_top.sv ====
// Pulse channel array with per-pair chaining mode and prescaler chaining
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "pulse_defs.svh"
// Overview of operation
// - Every channel has its own counter, 16-bit on even and 8-bit on odd channels, and channels can be joined for longer counts.
// - Independent byte mode runs each channel alone with 8-bit widths.
// - Joined word mode makes a pair one generator with a 16-bit counter and 16-bit widths.
// - Byte-chained mode makes one channel a prescaler that clocks the other channel.
// - A chained output side counts down on both edges of the prescaler output.
// - Word-chained mode builds two 16-bit counters, one prescaler and one output side.
// - The mode field lives only on even channels and sets that channel and the next odd one.
// - Channels form groups of four at bases 0 to 20, all offering the same modes.
// - Mode 00 is two byte generators, 01 is odd prescaler into even, 10 is one word pair.
// - In word chaining the base pair is the output side and the pair above is its prescaler.
// - Even independent or joined channels take any start source, all others software only.
// - The clock select gives one count per 1, 4, 16 or 64 clocks.
// - A joined pair uses one clock select; chained output sides ignore theirs.
// - Each level lasts the count period times the reload value plus one.

module pulse_chain_top #(
  parameter int GROUPS = `GROUP_COUNT
) (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  input  wire logic [GROUPS*`CH_PER_GROUP-1:0] gate_start,
  input  wire logic [GROUPS*`CH_PER_GROUP-1:0] timing_start,
  output logic      [GROUPS*`CH_PER_GROUP-1:0] pulse_out
);

  localparam int NCH = GROUPS * `CH_PER_GROUP;

  logic           rst_meta;
  logic           rst_n;
  logic [5:0]     div;
  logic [NCH-1:0] software_start_bit;
  logic [NCH-1:0] level;
  logic [NCH-1:0] level_d;
  logic [NCH-1:0] run;
  logic [7:0]     ctrl_rd [NCH];
  logic [7:0]     low_rd  [NCH];
  logic [7:0]     high_rd [NCH];
  logic [31:0]    next_rdata;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Free-running divider shared by all channels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  function automatic logic div_tick(input logic [1:0] sel, input logic [5:0] cnt);
    logic [5:0] mask;
    mask = `DIV_MASK_1;
    case (sel)
      2'h0:    mask = `DIV_MASK_1;
      2'h1:    mask = `DIV_MASK_4;
      2'h2:    mask = `DIV_MASK_16;
      default: mask = `DIV_MASK_64;
    endcase
    return (cnt & mask) == mask;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      software_start_bit <= '0;
    end else if (reg_wr && reg_addr == `OFS_START) begin
      software_start_bit <= reg_wdata[NCH-1:0];
    end
  end

  // Output and edge history come straight from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_out <= '0;
      level_d   <= '0;
    end else begin
      pulse_out <= level;
      level_d   <= level;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : ch
    localparam int PE  = c - (c % 2);
    localparam int GB  = c - (c % 4);
    localparam int POS = c % 4;
    localparam bit ODD = (c % 2) == 1;
    localparam int W   = ODD ? `BYTE_W : 2 * `BYTE_W;

    pulse_pkg::chain_mode_t mode;
    pulse_pkg::start_src_t  src;
    logic [1:0]             clk_sel;
    logic [7:0]             low_w;
    logic [7:0]             high_w;
    logic                   word_chain;
    logic                   wide;
    logic                   idle;
    logic                   chain_out;
    logic                   prescaler;
    logic                   ext_ok;
    logic                   edge_in;
    logic                   tick;
    logic                   hit_ctrl;
    logic [W-1:0]           low_n;
    logic [W-1:0]           high_n;

    assign hit_ctrl   = reg_wr && reg_addr == 8'(`OFS_CTRL + c);

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        clk_sel <= `CTRL_FIELD_RESET;
        low_w   <= `WIDTH_RESET;
        high_w  <= `WIDTH_RESET;
      end else begin
        if (hit_ctrl) begin
          clk_sel <= reg_wdata[`CTRL_CLK_LSB +: 2];
        end
        if (reg_wr && reg_addr == 8'(`OFS_LOW + c)) begin
          low_w <= reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == 8'(`OFS_HIGH + c)) begin
          high_w <= reg_wdata[7:0];
        end
      end
    end

    if (ODD) begin : g_odd
      // Odd channels hold no mode or source field
      assign mode    = pulse_pkg::MODE_BYTE;
      assign src     = pulse_pkg::SRC_SOFTWARE;
      assign edge_in = 1'b0;
      assign low_n   = low_w;
      assign high_n  = high_w;
    end else begin : g_even
      logic group_busy;

      assign group_busy = |run[GB+3:GB];
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mode <= pulse_pkg::chain_mode_t'(`CTRL_FIELD_RESET);
          src  <= pulse_pkg::start_src_t'(`CTRL_FIELD_RESET);
        end else if (hit_ctrl) begin
          src <= pulse_pkg::start_src_t'(reg_wdata[`CTRL_SRC_LSB +: 2]);
          // Mode is frozen while any channel of the group runs
          if (!group_busy) begin
            mode <= pulse_pkg::chain_mode_t'(reg_wdata[`CTRL_MODE_LSB +: 2]);
          end
        end
      end
      // Prescaler is the odd partner, or the upper pair in word chaining
      assign edge_in = word_chain ? (level[GB+2] ^ level_d[GB+2])
                                  : (level[c+1] ^ level_d[c+1]);
      // Joined widths take the odd partner's byte as the upper half
      assign low_n  = wide ? {ch[c+1].low_w, low_w} : {8'h00, low_w};
      assign high_n = wide ? {ch[c+1].high_w, high_w} : {8'h00, high_w};
    end

    // A lone 11 in either field decodes as independent bytes
    always_comb begin
      word_chain = ch[GB].mode == pulse_pkg::MODE_WORD_CHAIN &&
                   ch[GB+2].mode == pulse_pkg::MODE_WORD_CHAIN;
      idle      = 1'b0;
      wide      = 1'b0;
      chain_out = 1'b0;
      prescaler = 1'b0;
      if (word_chain) begin
        if (POS == 0) begin
          wide      = 1'b1;
          chain_out = 1'b1;
        end else if (POS == 2) begin
          wide      = 1'b1;
          prescaler = 1'b1;
        end else begin
          idle = 1'b1;
        end
      end else begin
        case (ch[PE].mode)
          pulse_pkg::MODE_BYTE_CHAIN: begin
            prescaler = ODD;
            chain_out = !ODD;
          end
          pulse_pkg::MODE_WORD: begin
            idle = ODD;
            wide = !ODD;
          end
          default: begin
            idle = 1'b0;
          end
        endcase
      end
    end

    // External starts only on even independent or joined channels
    assign ext_ok = !ODD && !chain_out && !prescaler && !idle;

    always_comb begin
      run[c] = software_start_bit[c];
      if (idle) begin
        run[c] = 1'b0;
      end else if (ext_ok && src == pulse_pkg::SRC_GATE) begin
        run[c] = gate_start[c];
      end else if (ext_ok && src == pulse_pkg::SRC_TIMING) begin
        run[c] = timing_start[c];
      end
    end

    // Chained output side ignores its clock select
    assign tick = chain_out ? edge_in : div_tick(clk_sel, div);

    pulse_slice #(
      .WIDTH (W)
    ) u_slice (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .run        (run[c]),
      .tick       (tick),
      .low_width  (low_n),
      .high_width (high_n),
      .level      (level[c])
    );

    assign ctrl_rd[c] = {2'h0, 2'(src), 2'(mode), clk_sel};
    assign low_rd[c]  = low_w;
    assign high_rd[c] = high_w;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (reg_addr[4:0] < 5'(NCH)) begin
      case (reg_addr & `OFS_BLOCK_MASK)
        `OFS_CTRL: next_rdata = {24'h000000, ctrl_rd[reg_addr[4:0]]};
        `OFS_LOW:  next_rdata = {24'h000000, low_rd[reg_addr[4:0]]};
        `OFS_HIGH: next_rdata = {24'h000000, high_rd[reg_addr[4:0]]};
        default:   next_rdata = '0;
      endcase
    end
    if (reg_addr == `OFS_START) begin
      next_rdata = 32'(software_start_bit);
    end else if (reg_addr == `OFS_LEVEL) begin
      next_rdata = 32'(level);
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

endmodule // pulse_chain_top

// ==== verilog/pulse_defs.svh ====
// Offsets, field positions, reset values and divider masks of the pulse array
`ifndef PULSE_DEFS_SVH
`define PULSE_DEFS_SVH

// Geometry
`define GROUP_COUNT      6
`define CH_PER_GROUP     4
`define BYTE_W           8

// Register map, word addresses on the register port
`define OFS_CTRL         8'h00
`define OFS_LOW          8'h20
`define OFS_HIGH         8'h40
`define OFS_START        8'h60
`define OFS_LEVEL        8'h61
`define OFS_BLOCK_MASK   8'he0

// Control word fields
`define CTRL_CLK_LSB     0
`define CTRL_MODE_LSB    2
`define CTRL_SRC_LSB     4

// Reset values
`define CTRL_FIELD_RESET 2'h0
`define WIDTH_RESET      8'h00

// Divider masks: one count per 1, 4, 16, 64 clocks
`define DIV_MASK_1       6'h00
`define DIV_MASK_4       6'h03
`define DIV_MASK_16      6'h0f
`define DIV_MASK_64      6'h3f

`endif

// ==== verilog/pulse_pkg.sv ====
// Types shared by the pulse channel array
package pulse_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW  = 2'h1,
    ST_HIGH = 2'h3
  } slice_state_t;

  typedef enum logic [1:0] {
    MODE_BYTE       = 2'h0,
    MODE_BYTE_CHAIN = 2'h1,
    MODE_WORD       = 2'h2,
    MODE_WORD_CHAIN = 2'h3
  } chain_mode_t;

  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'h0,
    SRC_GATE     = 2'h1,
    SRC_TIMING   = 2'h2
  } start_src_t;

endpackage

// ==== verilog/pulse_slice.sv ====
// One pulse counter: low phase then high phase, reloaded on each underflow
`timescale 1ns/100ps

module pulse_slice #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] low_width,
  input  wire logic [WIDTH-1:0] high_width,
  output logic                  level
);

  pulse_pkg::slice_state_t state;
  logic [WIDTH-1:0]        count;
  logic                    expire;

  assign expire = tick && (count == '0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= pulse_pkg::ST_IDLE;
    end else if (!run) begin
      // Stopping forces the low level even mid count
      state <= pulse_pkg::ST_IDLE;
    end else begin
      case (state)
        pulse_pkg::ST_IDLE: state <= pulse_pkg::ST_LOW;
        pulse_pkg::ST_LOW:  if (expire) state <= pulse_pkg::ST_HIGH;
        pulse_pkg::ST_HIGH: if (expire) state <= pulse_pkg::ST_LOW;
        default:            state <= pulse_pkg::ST_IDLE;
      endcase
    end
  end

  // Each level holds for (width + 1) ticks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!run || state == pulse_pkg::ST_IDLE) begin
      count <= low_width;
    end else if (tick) begin
      if (count != '0) begin
        count <= count - 1'b1;
      end else if (state == pulse_pkg::ST_LOW) begin
        count <= high_width;
      end else begin
        count <= low_width;
      end
    end
  end

  assign level = (state == pulse_pkg::ST_HIGH);

endmodule // pulse_slice

// ==== sim/pulse_chain_top_props.sv ====
// Port-level assertions for the pulse channel array
`timescale 1ns/100ps
`include "pulse_defs.svh"
module pulse_chain_top_props #(
  parameter int GROUPS = 6
) (
  input wire logic                            clk_sys,
  input wire logic                            resetn,
  input wire logic [7:0]                      reg_addr,
  input wire logic [31:0]                     reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [31:0]                     reg_rdata,
  input wire logic [GROUPS*`CH_PER_GROUP-1:0] gate_start,
  input wire logic [GROUPS*`CH_PER_GROUP-1:0] timing_start,
  input wire logic [GROUPS*`CH_PER_GROUP-1:0] pulse_out
);
  // Shadow of group 0 plus the whole start word, kept from the register port
  logic [7:0]                      lw [4];
  logic [7:0]                      hw [4];
  logic [1:0]                      sel [4];
  logic [1:0]                      m0;
  logic [1:0]                      m2;
  logic [GROUPS*`CH_PER_GROUP-1:0] st;
  logic [31:0]                     hi_cnt;
  logic [31:0]                     lo_cnt;
  logic                            seen;
  logic                            ok;
  int                              e_hi;
  int                              e_lo;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lw  <= '{default: 8'h00};
      hw  <= '{default: 8'h00};
      sel <= '{default: 2'h0};
      m0  <= 2'h0;
      m2  <= 2'h0;
      st  <= '0;
    end else if (reg_wr) begin
      if (reg_addr < 8'h04) sel[reg_addr[1:0]] <= reg_wdata[1:0];
      // Mode writes are dropped while the group runs
      if (reg_addr == 8'h00 && st[3:0] == 4'h0) m0 <= reg_wdata[3:2];
      if (reg_addr == 8'h02 && st[3:0] == 4'h0) m2 <= reg_wdata[3:2];
      if ((reg_addr & 8'hfc) == `OFS_LOW) lw[reg_addr[1:0]] <= reg_wdata[7:0];
      if ((reg_addr & 8'hfc) == `OFS_HIGH) hw[reg_addr[1:0]] <= reg_wdata[7:0];
      if (reg_addr == `OFS_START) st <= reg_wdata[GROUPS*`CH_PER_GROUP-1:0];
    end
  end

  // Run lengths of channel 0; first low after a start is not uniform, so skipped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= 32'h0;
      lo_cnt <= 32'h0;
      seen   <= 1'b0;
    end else begin
      hi_cnt <= pulse_out[0] ? hi_cnt + 32'h1 : 32'h0;
      lo_cnt <= pulse_out[0] ? 32'h0 : lo_cnt + 32'h1;
      seen   <= st[0] && (seen || (!pulse_out[0] && hi_cnt != 32'h0));
    end
  end

  always_comb begin
    ok = st[0] && (m0 == 2'h0 || st[1]) && (m0 != 2'h3 || st[3:2] == 2'h3);
    case (m0)
      2'h1: e_hi = (hw[0] + 1) * (hw[1] + 1) * (1 << (2 * sel[1]));
      2'h2: e_hi = ({hw[1], hw[0]} + 1) * (1 << (2 * sel[0]));
      2'h3: e_hi = ({hw[1], hw[0]} + 1) * ({hw[3], hw[2]} + 1) * (1 << (2 * sel[2]));
      default: e_hi = (hw[0] + 1) * (1 << (2 * sel[0]));
    endcase
    e_lo = (lw[0] + 1) * (1 << (2 * sel[0]));
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence fall_s;
    !pulse_out[0] && hi_cnt != 32'h0 && ok;
  endsequence
  sequence rise_s;
    pulse_out[0] && lo_cnt != 32'h0 && ok && seen;
  endsequence
  sequence quiet_s;
    (st == '0 && gate_start == '0 && timing_start == '0)[*5];
  endsequence

  odd_mode_zero_a:
    assert property (reg_rd && reg_addr < 8'h18 && reg_addr[0] |=> reg_rdata[5:2] == 4'h0)
    else $error("odd control word shows mode bits");
  byte_width_a:
    assert property (reg_rd && reg_addr[7:5] inside {3'h1, 3'h2} && reg_addr[4:0] < 5'h18
      |=> reg_rdata[31:8] == 24'h0) else $error("width register wider than a byte");
  byte_high_a:
    assert property (fall_s ##0 m0 == 2'h0 |-> hi_cnt == e_hi) else $error("byte high width");
  byte_low_a:
    assert property (rise_s ##0 m0 == 2'h0 |-> lo_cnt == e_lo) else $error("byte low width");
  word_high_a:
    assert property (fall_s ##0 m0 == 2'h2 |-> hi_cnt == e_hi) else $error("word high width");
  bchain_high_a:
    assert property (fall_s ##0 (m0 == 2'h1 && lw[1] == hw[1]) |-> hi_cnt == e_hi)
    else $error("byte chain high width");
  wchain_high_a:
    assert property (fall_s ##0 (m0 == 2'h3 && m2 == 2'h3 && lw[2] == hw[2] && lw[3] == hw[3])
      |-> hi_cnt == e_hi) else $error("word chain high width");
  idle_out_a:
    assert property (quiet_s |-> pulse_out == '0) else $error("output active with no start");
endmodule // pulse_chain_top_props

bind pulse_chain_top pulse_chain_top_props #(.GROUPS(GROUPS)) pulse_chain_top_props_i (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_start(gate_start),
  .timing_start(timing_start), .pulse_out(pulse_out));

// ==== sim/pulse_chain_top_tb.sv ====
// Self-checking bench for the pulse channel array
`timescale 1ns/100ps
`include "pulse_defs.svh"
module pulse_chain_top_tb;
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [23:0] gate_start;
  logic [23:0] timing_start;
  logic [23:0] pulse_out;
  int          errors;
  int          samples_checked;
  int          cycles;

  pulse_chain_top #(.GROUPS(6)) pulse_chain_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_start(gate_start),
    .timing_start(timing_start), .pulse_out(pulse_out));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Longest scenario is well under this; a hang ends the run here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop;
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Pairs of address and data byte
  task automatic wrs(input logic [15:0] q[$]);
    foreach (q[i]) wr(q[i][15:8], {24'h0, q[i][7:0]});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("read %h", a), reg_rdata, e);
  endtask

  // Wait out the stop latency before touching modes again
  task automatic halt;
    wr(`OFS_START, 32'h0);
    repeat (4) @(posedge clk_sys);
  endtask

  // Length in clocks of the next high pulse of one channel
  task automatic meas(input int ch, input logic [31:0] e);
    int n;
    n = 0;
    while (pulse_out[ch] !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while (pulse_out[ch] === 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    chk($sformatf("high width ch%0d", ch), n, e);
  endtask

  task automatic t_regs;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_LOW, 32'h0);
    wr(8'h01, 32'h3f);
    rd(8'h01, 32'h03);
    wr(8'h21, 32'h1ff);
    rd(8'h21, 32'hff);
    rd(8'h18, 32'h0);
  endtask

  task automatic t_byte;
    wrs('{16'h2000, 16'h4001});
    for (int s = 0; s < 4; s++) begin
      wrs('{16'h0000 | 16'(s), 16'h6001});
      meas(0, 32'h2 << (2 * s));
      meas(0, 32'h2 << (2 * s));
      halt;
    end
  endtask

  task automatic t_lock;
    wrs('{16'h0000, 16'h6001, 16'h0008});
    rd(8'h00, 32'h0);
    rd(`OFS_START, 32'h1);
    halt;
  endtask

  task automatic t_word;
    wrs('{16'h0008, 16'h2001, 16'h2100, 16'h4002, 16'h4101, 16'h6003});
    meas(0, 32'd259);
    // Low phase is two clocks, so this read lands in the next high phase
    rd(`OFS_LEVEL, 32'h1);
    halt;
  endtask

  // Output side's own clock select is set to 64 clocks and must not matter
  task automatic t_bchain;
    wrs('{16'h0007, 16'h0100, 16'h2102, 16'h4102, 16'h4001, 16'h6003});
    meas(0, 32'd6);
    meas(0, 32'd6);
    halt;
  endtask

  task automatic t_wchain;
    // Upper field first, so the lower field never holds a lone 11
    wrs('{16'h020c, 16'h000c, 16'h2201, 16'h2300, 16'h4201, 16'h4300});
    wrs('{16'h4002, 16'h4100, 16'h600f});
    meas(0, 32'd6);
    halt;
  endtask

  task automatic t_group;
    wrs('{16'h3400, 16'h5400});
    for (int s = 1; s < 3; s++) begin
      wr(8'h14, 32'h02 | (32'(s) << 4));
      @(posedge clk_sys);
      if (s == 1) gate_start[21:20] <= 2'h3;
      else timing_start[21:20] <= 2'h3;
      meas(20, 32'd16);
      chk("odd channel started", {31'h0, pulse_out[21]}, 32'h0);
      @(posedge clk_sys);
      gate_start   <= 24'h0;
      timing_start <= 24'h0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  initial begin
    resetn       = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 32'h0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    gate_start   = 24'h0;
    timing_start = 24'h0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_byte;
    t_lock;
    t_word;
    t_bchain;
    t_wchain;
    t_group;
    report_and_stop;
  end
endmodule // pulse_chain_top_tb
